// File: logic/dis_pkg.sv
// Package: constants, types and decode helpers for the integrator sequencer
package dis_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_COUNT   = 4'h8;

    localparam int SB_STATE   = 0;
    localparam int SB_MBSY    = 4;
    localparam int SB_TOG     = 5;
    localparam int SB_SIDE    = 6;
    localparam int SB_DRDY    = 7;
    localparam int SB_SETTLED = 8;
    localparam int SB_SPEED   = 9;
    localparam int SB_DIV     = 10;

    localparam int CB_RELEASE = 0;
    localparam int CB_SCLK_EN = 1;
    localparam logic CTRL_SCLK_EN_RST = 1'b1;

    // ****************************************************************
    // Pin indices and timing
    // ****************************************************************
    localparam int PIN_TOG  = 0;
    localparam int PIN_DIV  = 1;
    localparam int PIN_SPD  = 2;
    localparam int PIN_SCLK = 3;
    localparam int NPINS    = 4;

    localparam logic [1:0]  DIV_LAST    = 2'h3;
    // Internal clock periods per side; SETTLE_CNT counts results
    localparam logic [10:0] MRAZ_TICKS  = 11'h5BE;
    localparam logic [10:0] DRDY_TICKS  = 11'h564;
    localparam logic [2:0]  SETTLE_CNT  = 3'h4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_INIT, ST_1, ST_2, ST_3, ST_4, ST_5, ST_6, ST_7, ST_8
    } dis_state_t;

    typedef struct packed {
        logic int_a;
        logic int_b;
        logic meas_a;
        logic meas_b;
        logic grounded;
    } dis_path_t;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic integ_a(input dis_state_t s);
        return s == ST_3 || s == ST_5;
    endfunction : integ_a

    function automatic logic integ_b(input dis_state_t s);
        return s == ST_4 || s == ST_6;
    endfunction : integ_b

    function automatic logic is_ncont(input dis_state_t s);
        return s == ST_1 || s == ST_2 || s == ST_7 || s == ST_8;
    endfunction : is_ncont

endpackage : dis_pkg

// File: logic/dis_seq.sv
// Eight-state integrate/measure sequencer with Wishbone status port
//
// How it works
// - Select low: low-power mode reported.
// - Select high: high-speed mode reported.
// - Data-ready goes low when result available.
// - Data-ready timed by divided internal clock.
// - Asynchronous reset; host holds it long enough.
// - Each cycle measures and resets integrated sides.
// - Slow conversion pauses integration until caught up.
// - States 1/8 finish pending cycles, ordered.
// - States 2/7 prepare side A/B, no integration.
// - States 3-6 integrate as tabled.
// - Transitions use toggle and busy levels.
// - Busy asserted while any cycle runs.
// - Toggle while busy goes to 1/8, then 2/7.
// - Non-integrating states ground inputs.
// - Integrations always alternate sides.
// - Start in 1 if toggle high, else 8.
// - Graph symmetric under toggle inversion.
// - Continuous mode alternates states 4 and 5.
// - Data-ready held until shift clock high-low or a release write.
// - Divider input selects clock divided by four.
// - Ready 1380 periods, full cycle 1470 periods.
`timescale 1ns/1ps
module dis_seq
    import dis_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        integrate_toggle_i,
    input  wire logic        clock_quarter_divide_i,
    input  wire logic        speed_power_select_i,
    input  wire logic        serial_shift_clock_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             data_ready_n_o,
    output logic             result_side_o,
    output logic             high_speed_o,
    output dis_path_t        path_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NPINS-1:0] sync1_q;
    logic [NPINS-1:0] sync2_q;
    logic             tog;
    logic             div_en;
    logic             sclk;

    // No reset: the start state must see the true toggle level
    always_ff @(posedge sys_clk_i) begin
        sync1_q <= {serial_shift_clock_i, speed_power_select_i,
                    clock_quarter_divide_i, integrate_toggle_i};
        sync2_q <= sync1_q;
    end

    assign tog    = sync2_q[PIN_TOG];
    assign div_en = sync2_q[PIN_DIV];
    assign sclk   = sync2_q[PIN_SCLK];

    // ****************************************************************
    // Internal clock divider
    // ****************************************************************
    // Phase after reset is arbitrary relative to the toggle
    logic [1:0] div_q;
    logic       tick;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    assign tick = !div_en || div_q == DIV_LAST;

    // ****************************************************************
    // State machine
    // ****************************************************************
    dis_state_t state_q;
    dis_state_t state_d;
    logic       tog_q;
    logic       chg;
    logic       mbsy;
    logic       pend_a_q;
    logic       pend_b_q;
    logic       busy_q;

    assign chg  = tog != tog_q;
    assign mbsy = busy_q || pend_a_q || pend_b_q;

    // Level compare against the last sampled toggle, never an edge
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_INIT: state_d = tog ? ST_1 : ST_8;
            ST_1:    if (!mbsy) state_d = ST_2;
            ST_2:    if (chg) state_d = ST_3;
            ST_3:    if (chg) state_d = ST_4;
            ST_4:    if (chg) state_d = mbsy ? ST_1 : ST_5;
            ST_5:    if (chg) state_d = mbsy ? ST_8 : ST_4;
            ST_6:    if (chg) state_d = ST_5;
            ST_7:    if (chg) state_d = ST_6;
            ST_8:    if (!mbsy) state_d = ST_7;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_INIT;
            tog_q   <= 1'b0;
        end else if (tick) begin
            state_q <= state_d;
            tog_q   <= tog;
        end
    end

    // ****************************************************************
    // Measure/reset/auto-zero engine
    // ****************************************************************
    logic        leave;
    logic        set_a;
    logic        set_b;
    logic        start;
    logic        side_d;
    logic        side_q;
    logic [10:0] cnt_q;
    logic        hit;
    logic        done;

    assign leave = tick && state_d != state_q;
    assign set_a = leave && integ_a(state_q);
    assign set_b = leave && integ_b(state_q);
    assign start = tick && !busy_q && (pend_a_q || pend_b_q);
    assign hit   = tick && busy_q && cnt_q == DRDY_TICKS - 11'h1;
    assign done  = tick && busy_q && cnt_q == MRAZ_TICKS - 11'h1;

    // Both pending only in 1 or 8; 8 takes side B first
    always_comb begin
        if (pend_a_q && pend_b_q) begin
            side_d = state_q == ST_8;
        end else begin
            side_d = pend_b_q;
        end
    end

    // A new pending side wins over its own clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
        end else begin
            pend_a_q <= set_a || (pend_a_q && !(start && !side_d));
            pend_b_q <= set_b || (pend_b_q && !(start && side_d));
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            side_q <= 1'b0;
            cnt_q  <= '0;
        end else if (start) begin
            busy_q <= 1'b1;
            side_q <= side_d;
            cnt_q  <= '0;
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (tick && busy_q) begin
            cnt_q  <= cnt_q + 11'h1;
        end
    end

    // ****************************************************************
    // Data-ready and result bookkeeping
    // ****************************************************************
    logic       drdy_n_q;
    logic       seen_high_q;
    logic       sclk_rel;
    logic       wr_release;
    logic       ctrl_sclk_en_q;
    logic [2:0] results_q;
    logic       side_out_q;

    assign sclk_rel = ctrl_sclk_en_q && seen_high_q && !sclk;

    // Ready set wins over any release in the same cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drdy_n_q    <= 1'b1;
            seen_high_q <= 1'b0;
        end else if (hit) begin
            drdy_n_q    <= 1'b0;
            seen_high_q <= 1'b0;
        end else if (!drdy_n_q && (sclk_rel || wr_release)) begin
            drdy_n_q    <= 1'b1;
            seen_high_q <= 1'b0;
        end else if (!drdy_n_q && sclk && ctrl_sclk_en_q) begin
            seen_high_q <= 1'b1;
        end
    end

    // Saturating count so software can skip early results
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            results_q  <= '0;
            side_out_q <= 1'b0;
        end else if (hit) begin
            side_out_q <= side_q;
            if (results_q != SETTLE_CNT) begin
                results_q <= results_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            path_o       <= '{grounded: 1'b1, default: 1'b0};
            high_speed_o <= 1'b0;
        end else begin
            path_o.int_a    <= integ_a(state_q);
            path_o.int_b    <= integ_b(state_q);
            path_o.meas_a   <= busy_q && !side_q;
            path_o.meas_b   <= busy_q && side_q;
            path_o.grounded <= !integ_a(state_q) && !integ_b(state_q);
            high_speed_o    <= sync2_q[PIN_SPD];
        end
    end

    assign data_ready_n_o = drdy_n_q;
    assign result_side_o  = side_out_q;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // Ack one cycle after the request; writes act on the ack edge
    logic        ack_q;
    logic        req;
    logic        wr;
    logic [31:0] rd_d;
    logic [31:0] dat_q;

    assign req        = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr         = wb_cyc_i && wb_stb_i && wb_we_i && ack_q
                        && wb_adr_i == ADDR_CONTROL && wb_sel_i[0];
    assign wr_release = wr && wb_dat_i[CB_RELEASE];

    always_comb begin
        rd_d = '0;
        unique case (wb_adr_i)
            ADDR_STATUS: begin
                rd_d[SB_STATE +: 4] = state_q;
                rd_d[SB_MBSY]       = mbsy;
                rd_d[SB_TOG]        = tog;
                rd_d[SB_SIDE]       = side_out_q;
                rd_d[SB_DRDY]       = !drdy_n_q;
                rd_d[SB_SETTLED]    = results_q == SETTLE_CNT;
                rd_d[SB_SPEED]      = high_speed_o;
                rd_d[SB_DIV]        = div_en;
            end
            ADDR_CONTROL: rd_d[CB_SCLK_EN] = ctrl_sclk_en_q;
            ADDR_COUNT:   rd_d[2:0] = results_q;
            default:      rd_d = '0;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                dat_q <= rd_d;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_sclk_en_q <= CTRL_SCLK_EN_RST;
        end else if (wr) begin
            ctrl_sclk_en_q <= wb_dat_i[CB_SCLK_EN];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic last_b_q;
    logic any_end_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_b_q  <= 1'b0;
            any_end_q <= 1'b0;
        end else if (set_a || set_b) begin
            last_b_q  <= set_b;
            any_end_q <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_init;
        state_q == ST_INIT && tick && tog |=> state_q == ST_1;
    endproperty
    a_init: assert property (p_init) else $error("bad start state");

    property p_busy_tog;
        state_q == ST_4 && tick && chg && mbsy |=> state_q == ST_1;
    endproperty
    a_busy_tog: assert property (p_busy_tog)
        else $error("busy toggle missed state 1");

    property p_cont;
        state_q == ST_5 && tick && chg && !mbsy |=> state_q == ST_4;
    endproperty
    a_cont: assert property (p_cont) else $error("cont step wrong");

    property p_level;
        tick && !chg && integ_a(state_q) |=> $stable(state_q);
    endproperty
    a_level: assert property (p_level) else $error("move w/o toggle");

    property p_alt;
        (set_a || set_b) && any_end_q |-> set_a == last_b_q;
    endproperty
    a_alt: assert property (p_alt) else $error("sides not alternating");

    property p_ground;
        is_ncont(state_q) |=> path_o.grounded && !path_o.int_a;
    endproperty
    a_ground: assert property (p_ground) else $error("inputs not grounded");

    property p_order;
        start && state_q == ST_1 && pend_a_q |-> !side_d;
    endproperty
    a_order: assert property (p_order) else $error("side B before A");

    property p_ready;
        hit |=> !data_ready_n_o;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not shown");

    property p_hold;
        !data_ready_n_o && !sclk_rel && !wr_release |=> !data_ready_n_o;
    endproperty
    a_hold: assert property (p_hold) else $error("ready dropped early");

    property p_div;
        div_en && tick ##1 div_en |-> !tick;
    endproperty
    a_div: assert property (p_div) else $error("divider not by four");

    property p_meas;
        start && !side_d |=> busy_q && !side_q && !pend_a_q;
    endproperty
    a_meas: assert property (p_meas) else $error("side A not measured");

    c_cont:  cover property (state_q == ST_4 ##1 state_q == ST_5);
    c_ncont: cover property (state_q == ST_4 ##1 state_q == ST_1);
    c_ready: cover property ($fell(data_ready_n_o));

endmodule : dis_seq

// File: test/dis_host.sv
// Host controller model: drives the toggle and the readout strobe
`timescale 1ns/1ps
module dis_host (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic tog_req_i,
    input  wire logic release_req_i,
    input  wire logic data_ready_n_i,
    output logic      integrate_toggle_o,
    output logic      serial_shift_clock_o
);
    logic tog_q;
    logic sclk_q;

    // ****************************************************************
    // Toggle timing
    // ****************************************************************
    // Registered so the integration period moves in whole clocks
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tog_q <= 1'b0;
        end else begin
            tog_q <= tog_req_i;
        end
    end

    // ****************************************************************
    // Readout strobe
    // ****************************************************************
    // Idles low outside frames; never rises before ready is low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
        end else if (release_req_i && !data_ready_n_i) begin
            sclk_q <= 1'b1;
        end else if (!release_req_i) begin
            sclk_q <= 1'b0;
        end
    end

    assign integrate_toggle_o   = tog_q;
    assign serial_shift_clock_o = sclk_q;
endmodule : dis_host

// File: test/dual_integrator_sequencer_test.sv
// Self-checking bench for the integrator sequencer
`timescale 1ns/1ps
module dual_integrator_sequencer_test import dis_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic        tog_req = 1'b0;
    logic        rel_req = 1'b0;
    logic        divide = 1'b0;
    logic        speed = 1'b0;
    logic [31:0] dat_r;
    logic        ack;
    logic        drdy_n;
    logic        side;
    logic        hs;
    dis_path_t   path;
    logic        tog;
    logic        sclk;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;

    dis_seq u_dut (.sys_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .integrate_toggle_i(tog),
        .clock_quarter_divide_i(divide), .speed_power_select_i(speed),
        .serial_shift_clock_i(sclk), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .data_ready_n_o(drdy_n), .result_side_o(side),
        .high_speed_o(hs), .path_o(path));

    dis_host u_host (.sys_clk_i(clk), .rst_i(rst), .tog_req_i(tog_req),
        .release_req_i(rel_req), .data_ready_n_i(drdy_n),
        .integrate_toggle_o(tog), .serial_shift_clock_o(sclk));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task results;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
              output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        chk(ack, 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    // Counts cycles from the caller's edge until ready falls
    task wait_lo(input int lim, output int n);
        n = 0;
        while (drdy_n !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(drdy_n, 1'b0);
    endtask : wait_lo

    task rel_host;
        rel_req <= 1'b1;
        repeat (10) @(posedge clk);
        chk(drdy_n, 1'b0);
        rel_req <= 1'b0;
        repeat (8) @(posedge clk);
        chk(drdy_n, 1'b1);
    endtask : rel_host

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        logic [31:0] q;
        chk(drdy_n, 1'b1);
        chk(path, 5'h01);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q[3:0] == 4'h8 || q[3:0] == 4'h7, 1'b1);
        xfer(1'b0, ADDR_CONTROL, 32'h0, q);
        chk(q[1:0], 2'h2);
        xfer(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
    endtask : t_reset

    task t_speed;
        logic [31:0] q;
        for (int i = 1; i >= 0; i--) begin
            speed <= i[0];
            repeat (8) @(posedge clk);
            chk(hs, i[0]);
            xfer(1'b0, ADDR_STATUS, 32'h0, q);
            chk(q[SB_SPEED], i[0]);
        end
    endtask : t_speed

    // Long periods keep the sequencer in states 3 to 6
    task t_cont;
        int n;
        @(posedge clk);
        tog_req <= 1'b1;
        repeat (2000) @(posedge clk);
        chk(drdy_n, 1'b1);
        tog_req <= 1'b0;
        wait_lo(2000, n);
        chk(n >= 1380 && n <= 1392, 1'b1);
        chk(side, 1'b1);
        chk(path, 5'h12);
        rel_host();
        repeat (600) @(posedge clk);
        tog_req <= 1'b1;
        repeat (200) @(posedge clk);
        chk(path, 5'h0C);
        tog_req <= 1'b0;
    endtask : t_cont

    // Toggle while busy: pause, finish A then B, then prepare A
    task t_ncont;
        logic [31:0] q;
        int n;
        repeat (10) @(posedge clk);
        xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q[3:0], 4'h1);
        chk(q[SB_MBSY], 1'b1);
        chk({path.int_a, path.int_b, path.grounded}, 3'h1);
        wait_lo(4000, n);
        chk(side, 1'b0);
        xfer(1'b1, ADDR_CONTROL, 32'h3, q);
        repeat (6) @(posedge clk);
        chk(drdy_n, 1'b1);
        wait_lo(4000, n);
        chk(side, 1'b1);
        rel_host();
        n = 0;
        do begin
            xfer(1'b0, ADDR_STATUS, 32'h0, q);
            n++;
        end while (q[3:0] !== 4'h2 && n < 200);
        chk(q[3:0], 4'h2);
        chk(path, 5'h01);
        chk(q[SB_SETTLED], 1'b0);
    endtask : t_ncont

    task t_divide;
        logic [31:0] q;
        int n;
        divide <= 1'b1;
        repeat (20) @(posedge clk);
        tog_req <= 1'b1;
        repeat (100) @(posedge clk);
        chk(path, 5'h10);
        tog_req <= 1'b0;
        wait_lo(8000, n);
        chk(n >= 5520 && n <= 5560, 1'b1);
        chk(side, 1'b0);
        rel_host();
        xfer(1'b0, ADDR_COUNT, 32'h0, q);
        chk(q[2:0], 3'h4);
        xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q[SB_DIV], 1'b1);
        chk(q[SB_SETTLED], 1'b1);
        divide <= 1'b0;
    endtask : t_divide

    // Toggle while B busy from state 5: finish B then A, then prepare B
    task t_ncont_b;
        logic [31:0] q;
        int n;
        repeat (2000) @(posedge clk);
        tog_req <= 1'b1;
        repeat (20) @(posedge clk);
        tog_req <= 1'b0;
        repeat (10) @(posedge clk);
        xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q[3:0], 4'h8);
        chk(path, 5'h03);
        wait_lo(4000, n);
        chk(side, 1'b1);
        xfer(1'b1, ADDR_CONTROL, 32'h0, q);
        xfer(1'b0, ADDR_CONTROL, 32'h0, q);
        chk(q[1:0], 2'h0);
        rel_req <= 1'b1;
        repeat (10) @(posedge clk);
        rel_req <= 1'b0;
        repeat (8) @(posedge clk);
        chk(drdy_n, 1'b0);
        xfer(1'b1, ADDR_CONTROL, 32'h2, q);
        repeat (6) @(posedge clk);
        chk(drdy_n, 1'b0);
        rel_host();
        wait_lo(4000, n);
        chk(side, 1'b0);
        rel_host();
        n = 0;
        do begin
            xfer(1'b0, ADDR_STATUS, 32'h0, q);
            n++;
        end while (q[3:0] !== 4'h7 && n < 200);
        chk(q[3:0], 4'h7);
        chk(path, 5'h01);
    endtask : t_ncont_b

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    // Runs take about 18000 cycles; the ceiling leaves ample room
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        t_reset();
        t_speed();
        t_cont();
        t_ncont();
        t_divide();
        t_ncont_b();
        results();
    end
endmodule : dual_integrator_sequencer_test
